// ---- src/fcp_cfg.svh ----
// constants for the flash controller with protection and interrupt flags
`ifndef FCP_CFG_SVH
`define FCP_CFG_SVH
`define FCP_DATA_W 32
`define FCP_ADDR_W 6
`define FCP_NBLK 4
`define FCP_BLK_W 2
`define FCP_NWORDS 16
`define FCP_WIDX_W 4
`define FCP_WIDX_LSB 2
`define FCP_WIDX_MSB 5
`define FCP_BLK_LSB 4
`define FCP_NINT 7
`define FCP_INT_ACCESS 0
`define FCP_INT_DONE 1
`define FCP_INT_EEPROM 2
`define FCP_INT_VOLT 3
`define FCP_INT_DATA 4
`define FCP_INT_ERASE_ERR 5
`define FCP_INT_PROG_ERR 6
`define FCP_INT_NONE 7'h00
`define FCP_ERASED 32'hFFFFFFFF
`define FCP_ZERO 32'h00000000
`define FCP_USER_INIT 32'hFFFFFFFF
`define FCP_CLK_MHZ 40
`define FCP_PROG_NS 250
`define FCP_ERASE_NS 1000
`define FCP_PROG_CYC ((`FCP_PROG_NS * `FCP_CLK_MHZ + 999) / 1000)
`define FCP_ERASE_CYC ((`FCP_ERASE_NS * `FCP_CLK_MHZ + 999) / 1000)
`define FCP_CNT_W 8
`define FCP_CNT_ZERO 8'h00
`endif

// ---- src/fcp_pkg.sv ----
// types shared by the flash controller files
`include "fcp_cfg.svh"
package fcp_pkg;
   typedef enum logic [2:0] {FCP_FETCH, FCP_CPU_READ, FCP_DBG_READ, FCP_PROGRAM, FCP_ERASE} fcp_kind_t;
   typedef enum logic [1:0] {prot_state_open, prot_state_no_modify, prot_state_fetch_only} fcp_prot_t;
   typedef enum logic [1:0] {FCP_IDLE, FCP_BUSY, FCP_RESP} fcp_state_t;
   typedef struct packed {
      fcp_kind_t kind;
      logic [`FCP_ADDR_W-1:0] addr;
      logic [`FCP_DATA_W-1:0] wdata;
   } fcp_req_t;
   typedef struct packed {
      logic err;
      logic [`FCP_DATA_W-1:0] rdata;
   } fcp_resp_t;
   typedef struct packed {
      logic [`FCP_NINT-1:0] raw;
      logic [`FCP_NINT-1:0] masked;
   } fcp_int_t;
endpackage

// ---- src/fcp_sync3.sv ----
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module fcp_sync3 (
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic q_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         q_reg <= 1'b0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            q_reg <= s3_reg;
         end
      end
   end
   assign q = q_reg;
endmodule
`default_nettype wire

// ---- src/fcp_prot_cell.sv ----
// one block's protection state: volatile copy over a committed copy
`timescale 1ns/1ps
`default_nettype none
module fcp_prot_cell
   import fcp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic nv_init,
   input wire logic set_en,
   input var fcp_pkg::fcp_prot_t set_val,
   input wire logic save,
   output fcp_pkg::fcp_prot_t state
);
   logic reload_reg;
   fcp_prot_t vol_reg;
   fcp_prot_t vol_next;
   fcp_prot_t nv_reg;
   fcp_prot_t cur;
   logic stricter;
   // until the first edge after reset the committed copy is in force
   assign cur = reload_reg ? nv_reg : vol_reg; // [R16]
   assign stricter = (set_val > cur) && (set_val <= prot_state_fetch_only); // [R14]
   assign vol_next = (set_en && stricter) ? set_val : cur; // [R15]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reload_reg <= 1'b1;
         vol_reg <= prot_state_open;
      end else begin
         reload_reg <= 1'b0;
         vol_reg <= vol_next;
      end
   end
   // committed copy models nonvolatile cells: no reset, only a factory init
   always_ff @(posedge clk) begin
      if (nv_init) begin
         nv_reg <= prot_state_open;
      end else if (save) begin
         nv_reg <= cur; // [R17]
      end
   end
   assign state = cur;
endmodule
`default_nettype wire

// ---- src/fcp_top.sv ----
// flash controller: array, program/erase sequencer, protection, user regs, flags
// Contract
// R1: program or erase on no-modify or fetch-only block flags access, block untouched.
// R2: processor or debugger data read of fetch-only block flags access.
// R3: done flag set whenever a program or erase cycle ends.
// R4: eeprom interrupt sets the eeprom flag; cause held in completion status.
// R5: supply fault during an operation aborts it and sets voltage error.
// R6: program needing any 0 to 1 change sets data error.
// R7: failed erase sets erase failure flag.
// R8: failed program sets program failure flag.
// R9: each flag has an enable; only enabled flags reach the interrupt line.
// R10: raw flags and masked flags (raw AND enable) both readable.
// R11: requester programs one aligned word per request.
// R12: open blocks allow everything; no-modify blocks allow read and fetch only.
// R13: fetch-only blocks allow fetch only; data reads are blocked.
// R14: protection only moves to stricter states; fetch-only never changes.
// R15: attempts to relax protection are refused, setting kept.
// R16: uncommitted protection lasts until reset, then committed state returns.
// R17: commit stores current protection permanently across reset and power.
// R18: user registers 0 and 1 are writable and readable before commit.
// R19: separate commit makes user registers 0 and 1 permanent.
// R20: clear request drops selected raw flags only.
// R21: successful erase sets every bit of the block to one.
// R22: raw flags stick until cleared; enables reset to disabled.
`timescale 1ns/1ps
`default_nettype none
module fcp_top
   import fcp_pkg::*;
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic NV_INIT,
   input wire logic REQ_VALID,
   input var fcp_pkg::fcp_req_t REQ,
   output logic REQ_READY,
   output logic RESP_VALID,
   output fcp_pkg::fcp_resp_t RESP,

   input wire logic PROT_SET_VALID,
   input wire logic [`FCP_BLK_W-1:0] PROT_SET_BLOCK,
   input var fcp_pkg::fcp_prot_t PROT_SET_STATE,
   input wire logic PROT_SAVE,
   output fcp_pkg::fcp_prot_t [`FCP_NBLK-1:0] PROT_STATE,

   input wire logic USER_WR,
   input wire logic [`FCP_DATA_W-1:0] USER_WDATA0,
   input wire logic [`FCP_DATA_W-1:0] USER_WDATA1,
   input wire logic USER_SAVE,
   output logic [`FCP_DATA_W-1:0] USER0,
   output logic [`FCP_DATA_W-1:0] USER1,
   output logic USER_LOCKED,

   input wire logic [`FCP_NINT-1:0] INT_EN_SET,
   input wire logic [`FCP_NINT-1:0] INT_EN_CLR,
   input wire logic [`FCP_NINT-1:0] INT_CLEAR,
   output fcp_pkg::fcp_int_t INT_STATUS,
   output logic FLASH_IRQ,

   input wire logic EEPROM_IRQ,
   input wire logic [`FCP_DATA_W-1:0] EEPROM_STATUS,
   output logic [`FCP_DATA_W-1:0] EEPROM_DONE_STATUS,

   input wire logic SUPPLY_FAULT
);
   fcp_state_t state_reg;
   fcp_state_t state_next;
   fcp_kind_t op_kind_reg;
   logic [`FCP_WIDX_W-1:0] op_widx_reg;
   logic [`FCP_DATA_W-1:0] op_data_reg;
   logic [`FCP_CNT_W-1:0] cnt_reg;
   logic [`FCP_CNT_W-1:0] cnt_next;
   fcp_resp_t resp_reg;
   fcp_resp_t resp_next;

   logic [`FCP_DATA_W-1:0] mem_reg [`FCP_NWORDS];

   logic [`FCP_NINT-1:0] raw_reg;
   logic [`FCP_NINT-1:0] raw_next;
   logic [`FCP_NINT-1:0] en_reg;
   logic [`FCP_NINT-1:0] en_next;
   logic [`FCP_NINT-1:0] ev;
   logic [`FCP_DATA_W-1:0] eeprom_completion_status_reg;

   logic user_reload_reg;
   logic [`FCP_DATA_W-1:0] user0_reg;
   logic [`FCP_DATA_W-1:0] user1_reg;
   logic [`FCP_DATA_W-1:0] user0_nv_reg;
   logic [`FCP_DATA_W-1:0] user1_nv_reg;
   logic user_locked_nv_reg;
   logic [`FCP_DATA_W-1:0] user0_cur;
   logic [`FCP_DATA_W-1:0] user1_cur;

   logic fault;
   fcp_prot_t [`FCP_NBLK-1:0] prot;

   // request decode
   wire [`FCP_WIDX_W-1:0] req_widx = REQ.addr[`FCP_WIDX_MSB:`FCP_WIDX_LSB];
   wire [`FCP_BLK_W-1:0] req_blk = REQ.addr[`FCP_WIDX_MSB:`FCP_BLK_LSB];
   wire fcp_prot_t blk_prot = prot[req_blk];
   wire is_read = (REQ.kind == FCP_CPU_READ) || (REQ.kind == FCP_DBG_READ);
   wire is_fetch = (REQ.kind == FCP_FETCH);
   wire is_prog = (REQ.kind == FCP_PROGRAM);
   wire is_erase = (REQ.kind == FCP_ERASE);
   wire is_mod = is_prog || is_erase;
   wire idle = (state_reg == FCP_IDLE);
   wire answering = (state_reg == FCP_RESP);
   wire take = idle && REQ_VALID;
   wire read_blocked = is_read && (blk_prot == prot_state_fetch_only); // [R2] [R13]
   wire mod_blocked = is_mod && (blk_prot != prot_state_open); // [R1] [R12]
   wire [`FCP_DATA_W-1:0] stored = mem_reg[req_widx];
   // programming can only clear bits
   wire data_bad = is_prog && ((REQ.wdata & ~stored) != `FCP_ZERO); // [R6]
   wire start_op = take && is_mod && !mod_blocked && !data_bad;
   wire access_bad = read_blocked || mod_blocked;
   wire take_err = access_bad || data_bad;
   wire take_has_data = (is_read || is_fetch) && !read_blocked;
   wire [`FCP_DATA_W-1:0] take_rdata = take_has_data ? stored : `FCP_ZERO;
   wire [`FCP_CNT_W-1:0] cnt_prog = `FCP_CNT_W'(`FCP_PROG_CYC - 1);
   wire [`FCP_CNT_W-1:0] cnt_erase = `FCP_CNT_W'(`FCP_ERASE_CYC - 1);
   wire [`FCP_CNT_W-1:0] cnt_load = is_prog ? cnt_prog : cnt_erase;
   wire op_is_erase = (op_kind_reg == FCP_ERASE);
   wire busy = (state_reg == FCP_BUSY);
   wire op_abort = busy && fault; // [R5]
   wire op_finish = busy && !fault && (cnt_reg == `FCP_CNT_ZERO);
   wire op_end = op_abort || op_finish;
   wire [`FCP_BLK_W-1:0] op_blk = op_widx_reg[`FCP_WIDX_W-1:`FCP_WIDX_W-`FCP_BLK_W];

   // supply fault pin comes from outside the clock domain
   fcp_sync3 u_fault_sync (
      .clk(CLOCK),
      .rst(SYS_RST),
      .d(SUPPLY_FAULT),
      .q(fault)
   );

   // per-block protection
   genvar gb;
   generate
      for (gb = 0; gb < `FCP_NBLK; gb++) begin : g_prot
         localparam logic [`FCP_BLK_W-1:0] BI = gb[`FCP_BLK_W-1:0];
         fcp_prot_cell u_cell (
            .clk(CLOCK),
            .rst(SYS_RST),
            .nv_init(NV_INIT),
            .set_en(PROT_SET_VALID && (PROT_SET_BLOCK == BI)),
            .set_val(PROT_SET_STATE),
            .save(PROT_SAVE),
            .state(prot[gb])
         );
      end
   endgenerate

   // sequencer next state
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      resp_next = resp_reg;
      case (state_reg)
         FCP_IDLE: begin
            if (take) begin
               resp_next.err = take_err;
               resp_next.rdata = take_rdata;
               if (start_op) begin
                  state_next = FCP_BUSY;
                  cnt_next = cnt_load;
               end else begin
                  state_next = FCP_RESP;
               end
            end
         end
         FCP_BUSY: begin
            cnt_next = cnt_reg - 1'b1;
            if (op_end) begin
               state_next = FCP_RESP;
               resp_next.err = op_abort;
               resp_next.rdata = `FCP_ZERO;
            end
         end
         FCP_RESP: begin
            state_next = FCP_IDLE;
         end
         default: begin
            state_next = FCP_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_reg <= FCP_IDLE;
         cnt_reg <= `FCP_CNT_ZERO;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // answer word stands until the next answer
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         resp_reg <= '0;
      end else begin
         resp_reg <= resp_next;
      end
   end

   // operation latched at start, one word per request
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         op_kind_reg <= FCP_FETCH;
         op_widx_reg <= '0;
         op_data_reg <= `FCP_ZERO;
      end else if (start_op) begin
         op_kind_reg <= REQ.kind;
         op_widx_reg <= req_widx; // [R11]
         op_data_reg <= REQ.wdata;
      end
   end

   assign REQ_READY = idle;
   assign RESP_VALID = answering;
   assign RESP = resp_reg;

   // flash array cells, nonvolatile: no reset, factory init only
   genvar gw;
   generate
      for (gw = 0; gw < `FCP_NWORDS; gw++) begin : g_mem
         localparam logic [`FCP_WIDX_W-1:0] WI = gw[`FCP_WIDX_W-1:0];
         localparam logic [`FCP_BLK_W-1:0] WB = WI[`FCP_WIDX_W-1:`FCP_WIDX_W-`FCP_BLK_W];
         wire erase_hit = op_finish && op_is_erase && (op_blk == WB);
         wire prog_hit = op_finish && !op_is_erase && (op_widx_reg == WI);
         wire [`FCP_DATA_W-1:0] prog_word = mem_reg[gw] & op_data_reg;
         always_ff @(posedge CLOCK) begin
            if (NV_INIT) begin
               mem_reg[gw] <= `FCP_ERASED;
            end else if (erase_hit) begin
               mem_reg[gw] <= `FCP_ERASED; // [R21]
            end else if (prog_hit) begin
               mem_reg[gw] <= prog_word;
            end
         end
      end
   endgenerate

   // flag events
   wire ev_access = take && access_bad; // [R1] [R2]
   wire ev_data = take && !mod_blocked && data_bad; // [R6]
   wire ev_erase_err = op_abort && op_is_erase; // [R7]
   // a refused 0-to-1 program counts as a failed program
   wire ev_prog_err = (op_abort && !op_is_erase) || ev_data; // [R8]

   always_comb begin
      ev = `FCP_INT_NONE;
      ev[`FCP_INT_ACCESS] = ev_access;
      ev[`FCP_INT_DONE] = op_end; // [R3]
      ev[`FCP_INT_EEPROM] = EEPROM_IRQ; // [R4]
      ev[`FCP_INT_VOLT] = op_abort; // [R5]
      ev[`FCP_INT_DATA] = ev_data;
      ev[`FCP_INT_ERASE_ERR] = ev_erase_err;
      ev[`FCP_INT_PROG_ERR] = ev_prog_err;
   end

   // a flag event wins over a clear in the same cycle; an enable clear wins over an enable set
   assign raw_next = (raw_reg & ~INT_CLEAR) | ev; // [R20] [R22]
   assign en_next = (en_reg | INT_EN_SET) & ~INT_EN_CLR; // [R9]

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         raw_reg <= `FCP_INT_NONE;
      end else begin
         raw_reg <= raw_next;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         en_reg <= `FCP_INT_NONE; // [R22]
      end else begin
         en_reg <= en_next;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         eeprom_completion_status_reg <= `FCP_ZERO;
      end else if (EEPROM_IRQ) begin
         eeprom_completion_status_reg <= EEPROM_STATUS; // [R4]
      end
   end

   // interrupt status and line
   wire [`FCP_NINT-1:0] masked = raw_reg & en_reg; // [R9]
   assign INT_STATUS.raw = raw_reg; // [R10]
   assign INT_STATUS.masked = masked; // [R10]
   assign FLASH_IRQ = |masked; // [R9]
   assign EEPROM_DONE_STATUS = eeprom_completion_status_reg;
   assign PROT_STATE = prot;

   // user registers: volatile copy reloads committed copy after reset
   assign user0_cur = user_reload_reg ? user0_nv_reg : user0_reg;
   assign user1_cur = user_reload_reg ? user1_nv_reg : user1_reg;
   wire user_wr_ok = USER_WR && !user_locked_nv_reg; // [R18]
   wire user_save_ok = USER_SAVE && !user_locked_nv_reg;
   wire [`FCP_DATA_W-1:0] user0_next = user_wr_ok ? USER_WDATA0 : user0_cur; // [R18]
   wire [`FCP_DATA_W-1:0] user1_next = user_wr_ok ? USER_WDATA1 : user1_cur;

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         user_reload_reg <= 1'b1;
         user0_reg <= `FCP_USER_INIT;
         user1_reg <= `FCP_USER_INIT;
      end else begin
         user_reload_reg <= 1'b0;
         user0_reg <= user0_next;
         user1_reg <= user1_next;
      end
   end

   // committed user copy and its lock are nonvolatile
   always_ff @(posedge CLOCK) begin
      if (NV_INIT) begin
         user0_nv_reg <= `FCP_USER_INIT;
         user1_nv_reg <= `FCP_USER_INIT;
      end else if (user_save_ok) begin
         user0_nv_reg <= user0_cur; // [R19]
         user1_nv_reg <= user1_cur;
      end
   end

   // once set the lock refuses every later write and commit
   always_ff @(posedge CLOCK) begin
      if (NV_INIT) begin
         user_locked_nv_reg <= 1'b0;
      end else if (user_save_ok) begin
         user_locked_nv_reg <= 1'b1; // [R19]
      end
   end

   assign USER0 = user0_cur;
   assign USER1 = user1_cur;
   assign USER_LOCKED = user_locked_nv_reg;
endmodule
`default_nettype wire

// ---- bench/fcp_sva.sv ----
// assertions on the flash controller ports
`timescale 1ns/1ps
`default_nettype none
`include "fcp_cfg.svh"
module fcp_sva (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic NV_INIT,
   input wire logic REQ_VALID,
   input var fcp_pkg::fcp_req_t REQ,
   input wire logic REQ_READY,
   input wire logic RESP_VALID,
   input var fcp_pkg::fcp_resp_t RESP,
   input var fcp_pkg::fcp_prot_t [`FCP_NBLK-1:0] PROT_STATE,
   input wire logic [`FCP_DATA_W-1:0] USER0,
   input wire logic [`FCP_DATA_W-1:0] USER1,
   input wire logic USER_LOCKED,
   input wire logic [`FCP_NINT-1:0] INT_CLEAR,
   input var fcp_pkg::fcp_int_t INT_STATUS,
   input wire logic FLASH_IRQ,
   input wire logic EEPROM_IRQ,
   input wire logic [`FCP_DATA_W-1:0] EEPROM_STATUS,
   input wire logic [`FCP_DATA_W-1:0] EEPROM_DONE_STATUS
);
   import fcp_pkg::*;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST || NV_INIT);
   logic take;
   logic pe_reg;
   logic fo_reg;
   assign take = REQ_VALID && REQ_READY;
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pe_reg <= 1'h0;
         fo_reg <= 1'h0;
      end else if (take) begin
         pe_reg <= REQ.kind == FCP_PROGRAM || REQ.kind == FCP_ERASE;
         fo_reg <= PROT_STATE[REQ.addr[5:4]] == prot_state_fetch_only;
      end
   end
   property p_guard;
      take && (REQ.kind == FCP_PROGRAM || REQ.kind == FCP_ERASE) && PROT_STATE[REQ.addr[5:4]] != prot_state_open
         |=> RESP_VALID && RESP.err ##[0:1] INT_STATUS.raw[`FCP_INT_ACCESS];
   endproperty
   property p_read;
      take && (REQ.kind == FCP_CPU_READ || REQ.kind == FCP_DBG_READ) |=> RESP_VALID && RESP.err == fo_reg;
   endproperty
   property p_fetch;
      take && REQ.kind == FCP_FETCH |=> RESP_VALID && !RESP.err;
   endproperty
   property p_done;
      RESP_VALID && pe_reg && !RESP.err |-> ##[0:1] INT_STATUS.raw[`FCP_INT_DONE];
   endproperty
   property p_mask;
      (INT_STATUS.masked & ~INT_STATUS.raw) == `FCP_INT_NONE;
   endproperty
   property p_irq;
      FLASH_IRQ == |INT_STATUS.masked;
   endproperty
   property p_stick;
      (~INT_STATUS.raw & $past(INT_STATUS.raw) & ~$past(INT_CLEAR)) == `FCP_INT_NONE;
   endproperty
   property p_eeprom;
      EEPROM_IRQ |=> INT_STATUS.raw[`FCP_INT_EEPROM] && EEPROM_DONE_STATUS == $past(EEPROM_STATUS);
   endproperty
   property p_user;
      USER_LOCKED |=> $stable(USER0) && $stable(USER1);
   endproperty
   a_guard: assert property (p_guard) else $error("refused modify not flagged");
   a_read: assert property (p_read) else $error("data read answer wrong");
   a_fetch: assert property (p_fetch) else $error("fetch refused");
   a_done: assert property (p_done) else $error("done flag missing");
   a_mask: assert property (p_mask) else $error("masked flag without raw");
   a_irq: assert property (p_irq) else $error("irq differs from masked");
   a_stick: assert property (p_stick) else $error("raw flag dropped uncleared");
   a_eeprom: assert property (p_eeprom) else $error("eeprom flag or status");
   a_user: assert property (p_user) else $error("locked user value moved");
   for (genvar i = 0; i < `FCP_NBLK; i++) begin : g_prot
      property p_prot;
         PROT_STATE[i] >= $past(PROT_STATE[i]);
      endproperty
      a_prot: assert property (p_prot) else $error("protection relaxed");
   end
   c_err: cover property (RESP_VALID && RESP.err);
   c_irq: cover property (FLASH_IRQ);
   c_lock: cover property (USER_LOCKED);
endmodule
bind fcp_top fcp_sva chk (.CLOCK, .SYS_RST, .NV_INIT, .REQ_VALID, .REQ, .REQ_READY, .RESP_VALID, .RESP,
   .PROT_STATE, .USER0, .USER1, .USER_LOCKED, .INT_CLEAR, .INT_STATUS, .FLASH_IRQ, .EEPROM_IRQ,
   .EEPROM_STATUS, .EEPROM_DONE_STATUS);
`default_nettype wire

// ---- bench/fcp_host.sv ----
// requester model: processor core and debugger issuing flash accesses
`timescale 1ns/1ps
`default_nettype none
module fcp_host (
   input wire logic clk,
   input wire logic req_ready,
   input wire logic resp_valid,
   input var fcp_pkg::fcp_resp_t resp,
   output logic req_valid,
   output fcp_pkg::fcp_req_t req,
   output logic to
);
   import fcp_pkg::*;
   initial begin
      req_valid = 1'h0;
      req = '0;
      to = 1'h0;
   end
   // called just after a rising edge; returns just after one
   task automatic xfer(input fcp_kind_t k, input logic [5:0] a, input logic [31:0] d, output fcp_resp_t r);
      int n;
      repeat ($urandom % 3) begin
         @(posedge clk);
         #1;
      end
      req_valid = 1'h1;
      req = '{k, {a[5:2], 2'h0}, d};
      n = 0;
      while (req_ready !== 1'h1 && n < 50) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 50) to = 1'h1;
      @(posedge clk);
      #1;
      req_valid = 1'h0;
      // released bus shows no stale request
      req = ~req;
      n = 0;
      while (resp_valid !== 1'h1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      r = resp;
      if (n >= 100) to = 1'h1;
      @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the flash controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import fcp_pkg::*;
   logic CLOCK, SYS_RST, NV_INIT, REQ_VALID, REQ_READY, RESP_VALID, PROT_SET_VALID, PROT_SAVE, USER_WR;
   logic USER_SAVE, USER_LOCKED, FLASH_IRQ, EEPROM_IRQ, SUPPLY_FAULT, host_to;
   logic [1:0] PROT_SET_BLOCK;
   logic [31:0] USER_WDATA0, USER_WDATA1, USER0, USER1, EEPROM_STATUS, EEPROM_DONE_STATUS, s;
   logic [6:0] INT_EN_SET, INT_EN_CLR, INT_CLEAR;
   fcp_req_t REQ;
   fcp_resp_t RESP, r0;
   fcp_prot_t PROT_SET_STATE;
   fcp_prot_t [3:0] PROT_STATE;
   fcp_int_t INT_STATUS;
   int failures, samples_checked, m_prot[4], m_sav[4];
   logic [31:0] m_mem[16], m_raw, m_en, d;
   fcp_top uut (.CLOCK, .SYS_RST, .NV_INIT, .REQ_VALID, .REQ, .REQ_READY, .RESP_VALID, .RESP, .PROT_SET_VALID,
      .PROT_SET_BLOCK, .PROT_SET_STATE, .PROT_SAVE, .PROT_STATE, .USER_WR, .USER_WDATA0, .USER_WDATA1,
      .USER_SAVE, .USER0, .USER1, .USER_LOCKED, .INT_EN_SET, .INT_EN_CLR, .INT_CLEAR, .INT_STATUS,
      .FLASH_IRQ, .EEPROM_IRQ, .EEPROM_STATUS, .EEPROM_DONE_STATUS, .SUPPLY_FAULT);
   fcp_host host (.clk(CLOCK), .req_ready(REQ_READY), .resp_valid(RESP_VALID), .resp(RESP),
      .req_valid(REQ_VALID), .req(REQ), .to(host_to));
   initial begin
      CLOCK = 1'h0;
      forever #12.5 CLOCK = ~CLOCK;
   end
   task automatic print_verdict;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge CLOCK);
         #1;
      end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic flags;
      tick(2);
      chk(32'(INT_STATUS.raw), m_raw);
      chk(32'(INT_STATUS.masked), m_raw & m_en);
      chk(32'(FLASH_IRQ), 32'(|(m_raw & m_en)));
   endtask
   task automatic op(input int k, input logic [5:0] a, input logic [31:0] dv);
      fcp_resp_t r;
      int w, b;
      logic [31:0] ee, ed;
      w = a[5:2];
      b = a[5:4];
      ee = 0;
      ed = m_mem[w];
      if ((k == 1 || k == 2) && m_prot[b] == 2) begin
         ee = 1;
         ed = 0;
         m_raw[0] = 1'h1;
      end else if (k >= 3 && m_prot[b] != 0) begin
         ee = 1;
         m_raw[0] = 1'h1;
      end else if (k == 3 && (dv & ~m_mem[w]) != 0) begin
         ee = 1;
         m_raw[4] = 1'h1;
         m_raw[6] = 1'h1;
      end else if (k == 3) begin
         m_mem[w] = dv;
         m_raw[1] = 1'h1;
      end else if (k == 4) begin
         for (int i = 0; i < 4; i++) m_mem[b * 4 + i] = 32'hFFFFFFFF;
         m_raw[1] = 1'h1;
      end
      host.xfer(fcp_kind_t'(k), a, dv, r);
      chk(32'(r.err), ee);
      if (k < 3) chk(r.rdata, ed);
      flags;
   endtask
   task automatic prot_set(input int b, input int v);
      PROT_SET_VALID = 1'h1;
      PROT_SET_BLOCK = 2'(b);
      PROT_SET_STATE = fcp_prot_t'(v);
      tick(1);
      PROT_SET_VALID = 1'h0;
      if (v < 3 && v > m_prot[b]) m_prot[b] = v;
      tick(1);
      chk(32'(PROT_STATE[b]), m_prot[b]);
   endtask
   task automatic rst;
      SYS_RST = 1'h1;
      tick(4);
      SYS_RST = 1'h0;
      m_raw = 0;
      m_en = 0;
   endtask
   always @(posedge host_to) begin
      failures++;
      print_verdict;
   end
   initial begin
      #2000000;
      failures++;
      print_verdict;
   end
   initial begin
      {SYS_RST, PROT_SET_VALID, PROT_SAVE, USER_WR, USER_SAVE, EEPROM_IRQ, SUPPLY_FAULT} = '0;
      {PROT_SET_BLOCK, USER_WDATA0, USER_WDATA1, EEPROM_STATUS, INT_EN_SET, INT_EN_CLR, INT_CLEAR} = '0;
      PROT_SET_STATE = prot_state_open;
      NV_INIT = 1'h1;
      void'($urandom(41));
      foreach (m_mem[i]) m_mem[i] = 32'hFFFFFFFF;
      foreach (m_prot[i]) m_prot[i] = 0;
      rst;
      NV_INIT = 1'h0;
      flags;
      for (int i = 0; i < 30; i++) begin
         s = $urandom;
         d = s[0] ? m_mem[s[5:2]] & $urandom : $urandom;
         op($urandom % 5, s[5:0], d);
         if (i % 5 == 4) begin
            {INT_EN_SET, INT_EN_CLR, INT_CLEAR} = 21'($urandom);
            m_en = (m_en | INT_EN_SET) & ~32'(INT_EN_CLR);
            m_raw = m_raw & ~32'(INT_CLEAR);
            tick(1);
            {INT_EN_SET, INT_EN_CLR, INT_CLEAR} = '0;
            flags;
         end
      end
      fork
         host.xfer(FCP_ERASE, 6'h00, 32'h0, r0);
         begin
            tick(10);
            SUPPLY_FAULT = 1'h1;
         end
      join
      chk(32'(r0.err), 1);
      SUPPLY_FAULT = 1'h0;
      m_raw = m_raw | 32'h2A;
      tick(6);
      flags;
      op(1, 6'h00, 0);
      EEPROM_STATUS = $urandom;
      s = EEPROM_STATUS;
      EEPROM_IRQ = 1'h1;
      tick(1);
      EEPROM_IRQ = 1'h0;
      m_raw[2] = 1'h1;
      chk(EEPROM_DONE_STATUS, s);
      flags;
      prot_set(1, 1);
      prot_set(1, 0);
      prot_set(2, 2);
      prot_set(2, 1);
      prot_set(0, $urandom % 4);
      for (int b = 0; b < 4; b++) begin
         for (int k = 0; k < 5; k++) op(k, 6'(b * 16 + 4 * k), 0);
      end
      PROT_SAVE = 1'h1;
      tick(1);
      PROT_SAVE = 1'h0;
      m_sav = m_prot;
      prot_set(3, 2);
      {USER_WDATA0, USER_WDATA1} = {$urandom, $urandom};
      {USER_WR, s} = {1'h1, USER_WDATA0};
      d = USER_WDATA1;
      tick(1);
      USER_WR = 1'h0;
      chk(USER0, s);
      chk(USER1, d);
      USER_SAVE = 1'h1;
      tick(1);
      {USER_SAVE, USER_WR, USER_WDATA0} = {2'h1, ~s};
      tick(1);
      USER_WR = 1'h0;
      chk(USER0, s);
      chk(32'(USER_LOCKED), 1);
      rst;
      m_prot = m_sav;
      tick(1);
      for (int b = 0; b < 4; b++) chk(32'(PROT_STATE[b]), m_prot[b]);
      chk(USER0, s);
      chk(USER1, d);
      chk(32'(USER_LOCKED), 1);
      flags;
      print_verdict;
   end
endmodule
`default_nettype wire
